// >>> pkg/fcs_pkg.sv
// Constants and types shared by the flash command sequencer
package fcs_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned PROG_TIME_US = 40;
	localparam int unsigned PAGE_ERASE_TIME_US = 10000;
	localparam int unsigned MASS_ERASE_TIME_US = 200000;
	localparam int unsigned PROG_CYC = PROG_TIME_US * CLK_MHZ;
	localparam int unsigned PAGE_ERASE_CYC = PAGE_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned MASS_ERASE_CYC = MASS_ERASE_TIME_US * CLK_MHZ;
	localparam int unsigned TIMER_W = 32;

	// ----------------------------------------
	// Register map (indices; byte address is four times the index)
	// ----------------------------------------
	localparam int unsigned ADDR_W = 14;
	localparam logic [11:0] IDX_STAT_CMD = 12'hff8;
	localparam logic [11:0] IDX_PAGE_LOCK = 12'hff9;
	localparam logic [11:0] IDX_FREQ_HI = 12'hffa;
	localparam logic [11:0] IDX_FREQ_LO = 12'hffb;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int unsigned PAGE_MSB = 6;
	localparam int unsigned INFO_EN_BIT = 7;
	localparam int unsigned SECT_LSB = 4;
	localparam logic [7:0] PAGE_SEL_RST = 8'h00;
	localparam logic [7:0] SECT_LOCK_RST = 8'h00;
	localparam logic [15:0] FREQ_RST = 16'h0000;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h8c;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
	localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
	localparam logic [7:0] CMD_PROT_SEL = 8'h5e;

	// ----------------------------------------
	// Status codes
	// ----------------------------------------
	localparam logic [5:0] STS_LOCKED = 6'h00;
	localparam logic [5:0] STS_UNLOCK1 = 6'h01;
	localparam logic [5:0] STS_UNLOCK2 = 6'h02;
	localparam logic [5:0] STS_UNLOCKED = 6'h03;
	localparam logic [5:0] STS_PROT_SEL = 6'h04;
	localparam logic [5:0] STS_PROG = 6'h08;
	localparam logic [5:0] STS_PAGE_ERASE = 6'h10;
	localparam logic [5:0] STS_MASS_ERASE = 6'h20;

	// ----------------------------------------
	// AXI responses
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_LOCKED,
		ST_UNLOCK1,
		ST_UNLOCK2,
		ST_UNLOCKED,
		ST_PROT_SEL,
		ST_PROG,
		ST_PAGE_ERASE,
		ST_MASS_ERASE
	} fcs_state_t;

	// Controls presented to the flash array
	typedef struct packed {
		logic page_erase;
		logic mass_erase;
		logic prog;
		logic [6:0] page;
		logic info_en;
		logic [7:0] sector_lock;
		logic [15:0] freq;
	} fcs_flash_t;

endpackage

// >>> rtl/fcs_flash_sequencer.sv
// Flash command sequencer with an AXI4-Lite register slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
// What this block does
// - 73h first unlock, status reads 01
// - 8Ch next, status reads 02
// - Status 00 locked, 03 unlocked
// - 95h erases selected page, status 01_0xxx
// - 63h erases whole array, status 10_0xxx
// - Byte programming shows status 00_1xxx
// - 5Eh selects sector lock, status 04
// - Command write-only, status read-only, shared address
// - Seven-bit page number picks erased page
// - Info area enable bit gates access
// - Lock bits set only, block program/erase
// - Lock shares page select address after 5Eh
// - Sixteen-bit frequency in two byte registers
module fcs_flash_sequencer #(
	parameter int unsigned PAGE_ERASE_CYC = fcs_pkg::PAGE_ERASE_CYC,
	parameter int unsigned MASS_ERASE_CYC = fcs_pkg::MASS_ERASE_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [fcs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [fcs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic prog_req,
	input wire logic [2:0] prog_sector,
	output logic prog_accept,
	output fcs_pkg::fcs_flash_t flash_ctl
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	fcs_pkg::fcs_state_t state_reg;
	fcs_pkg::fcs_state_t state_next;
	logic [fcs_pkg::ADDR_W-1:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [7:0] page_sel_reg;
	logic [7:0] sect_lock_reg;
	logic [7:0] freq_hi_reg;
	logic [7:0] freq_lo_reg;
	logic tmr_load_reg;
	logic [fcs_pkg::TIMER_W-1:0] tmr_count_reg;
	logic tmr_done;
	logic wr_fire;
	logic [11:0] wr_idx;
	logic wr_mapped;
	logic wr_en;
	logic cmd_wr;
	logic page_wr;
	logic [7:0] cmd;
	logic page_locked;
	logic prog_ok;
	logic [11:0] rd_idx;
	logic [5:0] status;
	logic [7:0] rd_byte;
	logic rd_mapped;

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// A write commits once address and data are both held
	assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_idx = awaddr_reg[fcs_pkg::ADDR_W-1:2];
	assign wr_mapped = (wr_idx >= fcs_pkg::IDX_STAT_CMD) && (wr_idx <= fcs_pkg::IDX_FREQ_LO);
	assign wr_en = wr_fire && wr_mapped && wstrb0_reg;
	assign cmd = wdata_reg;
	assign cmd_wr = wr_en && (wr_idx == fcs_pkg::IDX_STAT_CMD);
	assign page_wr = wr_en && (wr_idx == fcs_pkg::IDX_PAGE_LOCK);

	// Sector of the selected page and of a program request
	assign page_locked = sect_lock_reg[page_sel_reg[fcs_pkg::PAGE_MSB:fcs_pkg::SECT_LSB]];
	assign prog_ok = prog_req && !sect_lock_reg[prog_sector];

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	// Next state from command writes and operation completion
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			fcs_pkg::ST_LOCKED: if (cmd_wr && cmd == fcs_pkg::CMD_UNLOCK1)
				state_next = fcs_pkg::ST_UNLOCK1;
			fcs_pkg::ST_UNLOCK1: if (cmd_wr)
				state_next = (cmd == fcs_pkg::CMD_UNLOCK2) ? fcs_pkg::ST_UNLOCK2
					: fcs_pkg::ST_LOCKED;
			fcs_pkg::ST_UNLOCK2: state_next = fcs_pkg::ST_UNLOCKED;
			fcs_pkg::ST_UNLOCKED: begin
				if (cmd_wr) begin
					if (cmd == fcs_pkg::CMD_PAGE_ERASE && !page_locked) begin
						state_next = fcs_pkg::ST_PAGE_ERASE;
					end else if (cmd == fcs_pkg::CMD_MASS_ERASE && sect_lock_reg == 8'h00) begin
						state_next = fcs_pkg::ST_MASS_ERASE;
					end else if (cmd == fcs_pkg::CMD_PROT_SEL) begin
						state_next = fcs_pkg::ST_PROT_SEL;
					end else begin
						state_next = fcs_pkg::ST_LOCKED;
					end
				end else if (prog_ok) begin
					state_next = fcs_pkg::ST_PROG;
				end
			end
			fcs_pkg::ST_PROT_SEL: if (cmd_wr || page_wr)
				state_next = fcs_pkg::ST_LOCKED;
			fcs_pkg::ST_PROG: if (tmr_done)
				state_next = fcs_pkg::ST_UNLOCKED;
			fcs_pkg::ST_PAGE_ERASE, fcs_pkg::ST_MASS_ERASE: if (tmr_done)
				state_next = fcs_pkg::ST_LOCKED;
		endcase
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg <= fcs_pkg::ST_LOCKED;
		end else begin
			state_reg <= state_next;
		end
	end

	// Operation timer start, loaded as a busy state is entered
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tmr_load_reg <= 1'b0;
			tmr_count_reg <= '0;
		end else begin
			tmr_load_reg <= 1'b0;
			if (state_reg == fcs_pkg::ST_UNLOCKED && state_next == fcs_pkg::ST_PAGE_ERASE) begin
				tmr_load_reg <= 1'b1;
				tmr_count_reg <= fcs_pkg::TIMER_W'(PAGE_ERASE_CYC);
			end else if (state_reg == fcs_pkg::ST_UNLOCKED && state_next == fcs_pkg::ST_MASS_ERASE) begin
				tmr_load_reg <= 1'b1;
				tmr_count_reg <= fcs_pkg::TIMER_W'(MASS_ERASE_CYC);
			end else if (state_reg == fcs_pkg::ST_UNLOCKED && state_next == fcs_pkg::ST_PROG) begin
				tmr_load_reg <= 1'b1;
				tmr_count_reg <= fcs_pkg::TIMER_W'(fcs_pkg::PROG_CYC);
			end
		end
	end

	fcs_op_timer #(
		.WIDTH(fcs_pkg::TIMER_W)
	) u_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.load(tmr_load_reg),
		.count(tmr_count_reg),
		.busy(),
		.done(tmr_done)
	);

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Page select; frozen while an erase runs
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			page_sel_reg <= fcs_pkg::PAGE_SEL_RST;
		end else if (page_wr && state_reg != fcs_pkg::ST_PROT_SEL
				&& state_reg != fcs_pkg::ST_PAGE_ERASE && state_reg != fcs_pkg::ST_MASS_ERASE) begin
			page_sel_reg <= wdata_reg;
		end
	end

	// Sector lock: ones only, reached after the select command
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sect_lock_reg <= fcs_pkg::SECT_LOCK_RST;
		end else if (page_wr && state_reg == fcs_pkg::ST_PROT_SEL) begin
			sect_lock_reg <= sect_lock_reg | wdata_reg;
		end
	end

	// Flash frequency bytes
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			freq_hi_reg <= fcs_pkg::FREQ_RST[15:8];
			freq_lo_reg <= fcs_pkg::FREQ_RST[7:0];
		end else begin
			if (wr_en && wr_idx == fcs_pkg::IDX_FREQ_HI)
				freq_hi_reg <= wdata_reg;
			if (wr_en && wr_idx == fcs_pkg::IDX_FREQ_LO)
				freq_lo_reg <= wdata_reg;
		end
	end

	// ----------------------------------------
	// Flash array controls
	// ----------------------------------------
	// Registered copy of the controls and the program accept pulse
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flash_ctl <= '0;
			prog_accept <= 1'b0;
		end else begin
			flash_ctl.page_erase <= (state_next == fcs_pkg::ST_PAGE_ERASE);
			flash_ctl.mass_erase <= (state_next == fcs_pkg::ST_MASS_ERASE);
			flash_ctl.prog <= (state_next == fcs_pkg::ST_PROG);
			flash_ctl.page <= page_sel_reg[fcs_pkg::PAGE_MSB:0];
			flash_ctl.info_en <= page_sel_reg[fcs_pkg::INFO_EN_BIT];
			flash_ctl.sector_lock <= sect_lock_reg;
			flash_ctl.freq <= {freq_hi_reg, freq_lo_reg};
			prog_accept <= (state_reg == fcs_pkg::ST_UNLOCKED) && !cmd_wr && prog_ok;
		end
	end

	// ----------------------------------------
	// Status and read decode
	// ----------------------------------------
	// Status code for each sequencer state
	always_comb begin
		unique case (state_reg)
			fcs_pkg::ST_LOCKED: status = fcs_pkg::STS_LOCKED;
			fcs_pkg::ST_UNLOCK1: status = fcs_pkg::STS_UNLOCK1;
			fcs_pkg::ST_UNLOCK2: status = fcs_pkg::STS_UNLOCK2;
			fcs_pkg::ST_UNLOCKED: status = fcs_pkg::STS_UNLOCKED;
			fcs_pkg::ST_PROT_SEL: status = fcs_pkg::STS_PROT_SEL;
			fcs_pkg::ST_PROG: status = fcs_pkg::STS_PROG;
			fcs_pkg::ST_PAGE_ERASE: status = fcs_pkg::STS_PAGE_ERASE;
			fcs_pkg::ST_MASS_ERASE: status = fcs_pkg::STS_MASS_ERASE;
		endcase
	end

	// Read data mux for the requested index
	assign rd_idx = s_axi_araddr[fcs_pkg::ADDR_W-1:2];
	always_comb begin
		rd_byte = 8'h00;
		rd_mapped = 1'b1;
		if (rd_idx == fcs_pkg::IDX_STAT_CMD) begin
			rd_byte = {2'b00, status};
		end else if (rd_idx == fcs_pkg::IDX_PAGE_LOCK) begin
			rd_byte = (state_reg == fcs_pkg::ST_PROT_SEL) ? sect_lock_reg
				: page_sel_reg;
		end else if (rd_idx == fcs_pkg::IDX_FREQ_HI) begin
			rd_byte = freq_hi_reg;
		end else if (rd_idx == fcs_pkg::IDX_FREQ_LO) begin
			rd_byte = freq_lo_reg;
		end else begin
			rd_mapped = 1'b0;
		end
	end

	// ----------------------------------------
	// AXI4-Lite write channels
	// ----------------------------------------
	// Address and data are taken independently, held until the write
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (wr_fire) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end else if (wr_fire) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= fcs_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// AXI4-Lite read channels
	// ----------------------------------------
	// One read at a time; data sampled as the address is taken
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= fcs_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, rd_byte};
				s_axi_rresp <= rd_mapped ? fcs_pkg::RESP_OKAY : fcs_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

// >>> rtl/fcs_op_timer.sv
// Countdown timer that measures the length of one flash operation
`timescale 1ns/1ps
module fcs_op_timer #(
	parameter int unsigned WIDTH = 32
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	output logic busy,
	output logic done
);

	logic [WIDTH-1:0] cnt_reg;

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// Load starts a run, done pulses on the last cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (load) begin
			cnt_reg <= count;
			busy <= 1'b1;
			done <= 1'b0;
		end else if (busy) begin
			cnt_reg <= cnt_reg - 1'b1;
			busy <= (cnt_reg > 1);
			done <= (cnt_reg <= 1);
		end else begin
			done <= 1'b0;
		end
	end

endmodule

// >>> testbench/fcs_flash_sequencer_assertions.sv
// Port-level checks for the flash command sequencer
`timescale 1ns/1ps
module fcs_flash_sequencer_assertions (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic prog_req,
	input wire logic [2:0] prog_sector,
	input wire logic prog_accept,
	input wire fcs_pkg::fcs_flash_t flash_ctl
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ----------------------------------------
	// Bus responses
	// ----------------------------------------
	bresp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp}))
		else $error("read response dropped early");
	rdata_upper_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");

	// ----------------------------------------
	// Operations and protection
	// ----------------------------------------
	accept_pulse_a: assert property (
		prog_accept |=> !prog_accept)
		else $error("program accept longer than one cycle");
	accept_prog_a: assert property (
		prog_accept |-> ##[0:3] flash_ctl.prog)
		else $error("program not started after accept");
	op_excl_a: assert property (
		!(flash_ctl.page_erase && flash_ctl.mass_erase)
		&& !(flash_ctl.prog && (flash_ctl.page_erase || flash_ctl.mass_erase)))
		else $error("two flash operations at once");
	lock_sticky_a: assert property (
		1'b1 |=> (flash_ctl.sector_lock & $past(flash_ctl.sector_lock))
		== $past(flash_ctl.sector_lock))
		else $error("sector lock bit cleared");
	page_prot_a: assert property (
		$rose(flash_ctl.page_erase) |-> !flash_ctl.sector_lock[flash_ctl.page[6:4]])
		else $error("page erase in locked sector");
	mass_prot_a: assert property (
		$rose(flash_ctl.mass_erase) |-> flash_ctl.sector_lock == 8'h00)
		else $error("mass erase with sector locked");
	prog_prot_a: assert property (
		prog_accept |-> $past(prog_req) && !flash_ctl.sector_lock[$past(prog_sector)])
		else $error("program accepted without request or in locked sector");
endmodule

bind fcs_flash_sequencer fcs_flash_sequencer_assertions u_fcs_flash_sequencer_assertions (
	.core_clk, .rst_n, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_req, .prog_sector, .prog_accept,
	.flash_ctl);

// >>> testbench/fcs_flash_sequencer_test.sv
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
module fcs_flash_sequencer_test;
	logic core_clk, rst_n, prog_req, prog_accept;
	logic [13:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot, prog_sector;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	fcs_pkg::fcs_flash_t flash_ctl;
	int err_total, samples_checked, cycles;
	localparam logic [13:0] A_CMD = {fcs_pkg::IDX_STAT_CMD, 2'b00};
	localparam logic [13:0] A_PAGE = {fcs_pkg::IDX_PAGE_LOCK, 2'b00};
	localparam logic [13:0] A_FHI = {fcs_pkg::IDX_FREQ_HI, 2'b00};
	localparam logic [13:0] A_FLO = {fcs_pkg::IDX_FREQ_LO, 2'b00};

	fcs_flash_sequencer #(.PAGE_ERASE_CYC(20), .MASS_ERASE_CYC(40)) u_fcs_flash_sequencer (
		.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_req, .prog_sector,
		.prog_accept, .flash_ctl);

	// ----------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Cut a hang short
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			err_total++;
			summarize();
		end
	end

	task summarize;
		if (err_total == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, exp, seen);
		end
	endtask

	// Address and data offered together, each released when taken
	task wr(input logic [13:0] a, input logic [7:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [13:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task st(input logic [31:0] e);
		rd(A_CMD);
		chk("status", v, e);
	endtask

	// Read status until it matches or the tries run out
	task poll(input logic [31:0] e, input int n);
		for (int i = 0; i < n; i++) begin
			rd(A_CMD);
			if (v === e) break;
		end
		chk("status poll", v, e);
	endtask

	task unl;
		wr(A_CMD, fcs_pkg::CMD_UNLOCK1);
		wr(A_CMD, fcs_pkg::CMD_UNLOCK2);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		st(32'h0);
		rd(A_PAGE);
		chk("page select", v, 32'h0);
		chk("freq out", 32'(flash_ctl.freq), 32'h0);
	endtask

	task t_freq;
		wr(A_FHI, 8'ha5);
		chk("wr resp", 32'(r), 32'(fcs_pkg::RESP_OKAY));
		wr(A_FLO, 8'h3c);
		rd(A_FHI);
		chk("rd resp", 32'(r), 32'(fcs_pkg::RESP_OKAY));
		chk("freq high", v, 32'ha5);
		rd(A_FLO);
		chk("freq low", v, 32'h3c);
		chk("freq out", 32'(flash_ctl.freq), 32'ha53c);
		// Byte lane zero off: write answered but ignored
		s_axi_wstrb <= 4'h0;
		wr(A_FHI, 8'hff);
		s_axi_wstrb <= 4'h1;
		rd(A_FHI);
		chk("masked write", v, 32'ha5);
		wr(14'h0010, 8'h55);
		chk("bad wr resp", 32'(r), 32'(fcs_pkg::RESP_SLVERR));
		rd(14'h0010);
		chk("bad rd resp", 32'(r), 32'(fcs_pkg::RESP_SLVERR));
		chk("bad rd data", v, 32'h0);
	endtask

	task t_unlock;
		wr(A_CMD, fcs_pkg::CMD_UNLOCK1);
		st(32'h1);
		wr(A_CMD, fcs_pkg::CMD_UNLOCK2);
		st(32'h3);
		wr(A_CMD, 8'h11);
		st(32'h0);
		wr(A_CMD, fcs_pkg::CMD_UNLOCK2);
		st(32'h0);
		wr(A_CMD, fcs_pkg::CMD_UNLOCK1);
		wr(A_CMD, fcs_pkg::CMD_UNLOCK1);
		st(32'h0);
	endtask

	task t_page;
		wr(A_PAGE, 8'hb5);
		@(posedge core_clk);
		chk("page out", 32'(flash_ctl.page), 32'h35);
		chk("info on", 32'(flash_ctl.info_en), 32'h1);
		unl;
		wr(A_CMD, fcs_pkg::CMD_PAGE_ERASE);
		st(32'h10);
		chk("page erase", 32'(flash_ctl.page_erase), 32'h1);
		wr(A_CMD, fcs_pkg::CMD_MASS_ERASE);
		st(32'h10);
		poll(32'h0, 20);
		wr(A_PAGE, 8'h35);
		@(posedge core_clk);
		chk("info off", 32'(flash_ctl.info_en), 32'h0);
	endtask

	task t_mass;
		unl;
		wr(A_CMD, fcs_pkg::CMD_MASS_ERASE);
		st(32'h20);
		chk("mass erase", 32'(flash_ctl.mass_erase), 32'h1);
		poll(32'h0, 30);
	endtask

	task t_prog;
		unl;
		prog_req <= 1'b1;
		prog_sector <= 3'h7;
		do @(posedge core_clk); while (!prog_accept);
		prog_req <= 1'b0;
		st(32'h8);
		chk("prog out", 32'(flash_ctl.prog), 32'h1);
		poll(32'h3, 1500);
		// Unknown command while unlocked relocks before the next scenario
		wr(A_CMD, 8'h00);
		st(32'h0);
	endtask

	task t_prot;
		int n;
		n = 0;
		unl;
		wr(A_CMD, fcs_pkg::CMD_PROT_SEL);
		st(32'h4);
		rd(A_PAGE);
		chk("lock read", v, 32'h0);
		wr(A_PAGE, 8'h01);
		st(32'h0);
		rd(A_PAGE);
		chk("page after lock", v, 32'h35);
		unl;
		wr(A_CMD, fcs_pkg::CMD_PROT_SEL);
		wr(A_PAGE, 8'h02);
		st(32'h0);
		chk("lock out", 32'(flash_ctl.sector_lock), 32'h3);
		wr(A_PAGE, 8'h05);
		unl;
		wr(A_CMD, fcs_pkg::CMD_PAGE_ERASE);
		st(32'h0);
		unl;
		wr(A_CMD, fcs_pkg::CMD_MASS_ERASE);
		st(32'h0);
		unl;
		prog_req <= 1'b1;
		prog_sector <= 3'h0;
		repeat (8) begin
			@(posedge core_clk);
			if (prog_accept) n++;
		end
		prog_req <= 1'b0;
		chk("locked accepts", 32'(n), 32'h0);
		st(32'h3);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		s_axi_awaddr = 14'h0;
		s_axi_araddr = 14'h0;
		s_axi_awprot = 3'h0;
		s_axi_arprot = 3'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h1;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		prog_req = 1'b0;
		prog_sector = 3'h0;
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset;
		t_freq;
		t_unlock;
		t_page;
		t_mass;
		t_prog;
		t_prot;
		summarize();
	end
endmodule
